// ===== shared/dhbdc_params.svh
// Timing constants and timer width for the dual bridge drive control
`ifndef DHBDC_PARAMS_SVH
`define DHBDC_PARAMS_SVH

// Core clock period in picoseconds (100 MHz)
`define DHBDC_CLK_PS          10000
// Constant off time, ns
`define DHBDC_OFF_TIME_NS     20000
// Blanking time after turn-on, ps (3.75 us)
`define DHBDC_BLANK_PS        3750000
// Overcurrent deglitch, ns (2.3 us)
`define DHBDC_DEGLITCH_NS     2300
// Overcurrent retry period, ns (1.4 ms)
`define DHBDC_RETRY_NS        1400000
// Dead time between FET switching, ns
`define DHBDC_DEAD_NS         450
// Least times round up, counts in cycles
`define DHBDC_OFF_CYC     ((`DHBDC_OFF_TIME_NS * 1000 + `DHBDC_CLK_PS - 1) / `DHBDC_CLK_PS)
`define DHBDC_BLANK_CYC   ((`DHBDC_BLANK_PS + `DHBDC_CLK_PS - 1) / `DHBDC_CLK_PS)
`define DHBDC_DEG_CYC     ((`DHBDC_DEGLITCH_NS * 1000 + `DHBDC_CLK_PS - 1) / `DHBDC_CLK_PS)
`define DHBDC_RETRY_CYC   ((`DHBDC_RETRY_NS * 1000 + `DHBDC_CLK_PS - 1) / `DHBDC_CLK_PS)
`define DHBDC_DEAD_CYC    ((`DHBDC_DEAD_NS * 1000 + `DHBDC_CLK_PS - 1) / `DHBDC_CLK_PS)
// Timer width
`define DHBDC_TW              18

`endif

// ===== shared/dhbdc_pkg.sv
// Types shared by the dual bridge drive control
`default_nettype none
package dhbdc_pkg;
    // Bridge output level per half: off (Z), high side on, low side on
    typedef enum logic [2:0] {
        DHBDC_HALF_OFF  = 3'b001,
        DHBDC_HALF_HIGH = 3'b010,
        DHBDC_HALF_LOW  = 3'b100
    } dhbdc_half_t;

    // Chopper state per bridge
    typedef enum logic [3:0] {
        DHBDC_CH_IDLE  = 4'b0001,
        DHBDC_CH_BLANK = 4'b0010,
        DHBDC_CH_SENSE = 4'b0100,
        DHBDC_CH_OFF   = 4'b1000
    } dhbdc_chop_t;

    // Overcurrent state per bridge
    typedef enum logic [2:0] {
        DHBDC_OC_RUN   = 3'b001,
        DHBDC_OC_DEG   = 3'b010,
        DHBDC_OC_SHUT  = 3'b100
    } dhbdc_oc_t;
endpackage
`default_nettype wire

// ===== design/dhbdc_sync.sv
// Two-flop synchroniser for a bus of pin inputs
`default_nettype none
module dhbdc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             resetn,
    // Asynchronous in, synchronised out
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage_one;

    // First stage read only by the second stage
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            stage_one <= '0;
            sync_out  <= '0;
        end else begin
            stage_one <= pin_in;
            sync_out  <= stage_one;
        end
    end
endmodule
`default_nettype wire

// ===== design/dhbdc_bridge.sv
// One H-bridge: decode, chopper, overcurrent and dead time
`include "dhbdc_params.svh"
`default_nettype none
module dhbdc_bridge (
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  resetn,
    // Synchronised control and status
    input  wire logic                  ctl_one,
    input  wire logic                  ctl_two,
    input  wire logic                  sense_trip,
    input  wire logic                  fet_limit,
    input  wire logic                  force_off,
    // Half-bridge gate enables
    output logic                       hs_one,
    output logic                       ls_one,
    output logic                       hs_two,
    output logic                       ls_two,
    // Status
    output logic                       oc_fault,
    output logic                       chop_off
);
    typedef logic [`DHBDC_TW-1:0] dhbdc_cnt_t;

    dhbdc_pkg::dhbdc_chop_t chop, next_chop;
    dhbdc_pkg::dhbdc_oc_t   oc, next_oc;
    dhbdc_cnt_t             chop_cnt, next_chop_cnt, oc_cnt, next_oc_cnt;
    dhbdc_cnt_t             dead_cnt, next_dead_cnt;
    logic [3:0]             want, gates, next_gates;
    logic                   driving;

    // Decode one half from the requested level
    function automatic logic [1:0] half_gates(input dhbdc_pkg::dhbdc_half_t h);
        half_gates = (h == dhbdc_pkg::DHBDC_HALF_HIGH) ? 2'b10 :
                     (h == dhbdc_pkg::DHBDC_HALF_LOW)  ? 2'b01 : 2'b00;
    endfunction

    // Driving means one half high, the other low
    assign driving = ctl_one ^ ctl_two;

    // Chopper: blank after turn-on, sense, then fixed slow-decay off time
    always_comb begin
        next_chop     = chop;
        next_chop_cnt = chop_cnt;
        unique case (chop)
            dhbdc_pkg::DHBDC_CH_IDLE: begin
                if (driving) begin
                    next_chop     = dhbdc_pkg::DHBDC_CH_BLANK;
                    next_chop_cnt = dhbdc_cnt_t'(`DHBDC_BLANK_CYC - 1);
                end
            end
            dhbdc_pkg::DHBDC_CH_BLANK: begin
                if (!driving) begin
                    next_chop = dhbdc_pkg::DHBDC_CH_IDLE;
                end else if (chop_cnt == '0) begin
                    next_chop = dhbdc_pkg::DHBDC_CH_SENSE;
                end else begin
                    next_chop_cnt = chop_cnt - 1'b1;
                end
            end
            dhbdc_pkg::DHBDC_CH_SENSE: begin
                if (!driving) begin
                    next_chop = dhbdc_pkg::DHBDC_CH_IDLE;
                end else if (sense_trip) begin
                    next_chop     = dhbdc_pkg::DHBDC_CH_OFF;
                    next_chop_cnt = dhbdc_cnt_t'(`DHBDC_OFF_CYC - 1);
                end
            end
            dhbdc_pkg::DHBDC_CH_OFF: begin
                if (chop_cnt == '0) begin
                    next_chop     = driving ? dhbdc_pkg::DHBDC_CH_BLANK
                                            : dhbdc_pkg::DHBDC_CH_IDLE;
                    next_chop_cnt = dhbdc_cnt_t'(`DHBDC_BLANK_CYC - 1);
                end else begin
                    next_chop_cnt = chop_cnt - 1'b1;
                end
            end
        endcase
        if (force_off || oc != dhbdc_pkg::DHBDC_OC_RUN && oc != dhbdc_pkg::DHBDC_OC_DEG) begin
            next_chop = dhbdc_pkg::DHBDC_CH_IDLE;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            chop     <= dhbdc_pkg::DHBDC_CH_IDLE;
            chop_cnt <= '0;
        end else begin
            chop     <= next_chop;
            chop_cnt <= next_chop_cnt;
        end
    end

    // Overcurrent: deglitch, shut this bridge only, retry after period
    always_comb begin
        next_oc     = oc;
        next_oc_cnt = oc_cnt;
        unique case (oc)
            dhbdc_pkg::DHBDC_OC_RUN: begin
                if (fet_limit) begin
                    next_oc     = dhbdc_pkg::DHBDC_OC_DEG;
                    next_oc_cnt = dhbdc_cnt_t'(`DHBDC_DEG_CYC - 1);
                end
            end
            dhbdc_pkg::DHBDC_OC_DEG: begin
                if (!fet_limit) begin
                    next_oc = dhbdc_pkg::DHBDC_OC_RUN;
                end else if (oc_cnt == '0) begin
                    next_oc     = dhbdc_pkg::DHBDC_OC_SHUT;
                    next_oc_cnt = dhbdc_cnt_t'(`DHBDC_RETRY_CYC - 1);
                end else begin
                    next_oc_cnt = oc_cnt - 1'b1;
                end
            end
            dhbdc_pkg::DHBDC_OC_SHUT: begin
                if (oc_cnt == '0) begin
                    next_oc = dhbdc_pkg::DHBDC_OC_RUN;
                end else begin
                    next_oc_cnt = oc_cnt - 1'b1;
                end
            end
        endcase
        if (force_off) begin
            next_oc = dhbdc_pkg::DHBDC_OC_RUN;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            oc     <= dhbdc_pkg::DHBDC_OC_RUN;
            oc_cnt <= '0;
        end else begin
            oc     <= next_oc;
            oc_cnt <= next_oc_cnt;
        end
    end

    // Requested gates from the truth table, chopper and faults
    always_comb begin
        dhbdc_pkg::dhbdc_half_t h1;
        dhbdc_pkg::dhbdc_half_t h2;
        h1 = dhbdc_pkg::DHBDC_HALF_OFF;
        h2 = dhbdc_pkg::DHBDC_HALF_OFF;
        unique case ({ctl_one, ctl_two})
            2'b00: begin // Coast, all FETs off
                h1 = dhbdc_pkg::DHBDC_HALF_OFF;
                h2 = dhbdc_pkg::DHBDC_HALF_OFF;
            end
            2'b01: begin // Reverse
                h1 = dhbdc_pkg::DHBDC_HALF_LOW;
                h2 = dhbdc_pkg::DHBDC_HALF_HIGH;
            end
            2'b10: begin // Forward
                h1 = dhbdc_pkg::DHBDC_HALF_HIGH;
                h2 = dhbdc_pkg::DHBDC_HALF_LOW;
            end
            2'b11: begin // Brake, both low sides on
                h1 = dhbdc_pkg::DHBDC_HALF_LOW;
                h2 = dhbdc_pkg::DHBDC_HALF_LOW;
            end
        endcase
        if (chop == dhbdc_pkg::DHBDC_CH_OFF) begin
            h1 = dhbdc_pkg::DHBDC_HALF_LOW; // Slow decay during off time
            h2 = dhbdc_pkg::DHBDC_HALF_LOW;
        end
        if (force_off || oc == dhbdc_pkg::DHBDC_OC_SHUT) begin
            h1 = dhbdc_pkg::DHBDC_HALF_OFF;
            h2 = dhbdc_pkg::DHBDC_HALF_OFF;
        end
        want = {half_gates(h1), half_gates(h2)};
    end

    // Dead time: a gate that turns on waits with all FETs of its half off
    always_comb begin
        next_gates    = gates;
        next_dead_cnt = dead_cnt;
        if (want == gates) begin
            next_dead_cnt = '0;
        end else if (dead_cnt != '0) begin
            next_gates    = gates & want;
            next_dead_cnt = dead_cnt - 1'b1;
            if (dead_cnt == dhbdc_cnt_t'(1)) begin
                next_gates = want;
            end
        end else if ((want & ~gates) == '0) begin
            next_gates = want; // Turning off only: immediate
        end else begin
            next_gates    = gates & want;
            next_dead_cnt = dhbdc_cnt_t'(`DHBDC_DEAD_CYC);
        end
        if (force_off) begin
            next_gates    = '0;
            next_dead_cnt = '0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            gates    <= '0;
            dead_cnt <= '0;
        end else begin
            gates    <= next_gates;
            dead_cnt <= next_dead_cnt;
        end
    end

    assign {hs_one, ls_one, hs_two, ls_two} = gates;
    assign oc_fault = (oc == dhbdc_pkg::DHBDC_OC_SHUT);
    assign chop_off = (chop == dhbdc_pkg::DHBDC_CH_OFF);

    // A half never has both FETs on
    chk_no_shoot: assert property (@(posedge core_clk) disable iff (!resetn)
        !(hs_one && ls_one) && !(hs_two && ls_two))
        else $error("Shoot-through on a half bridge");

    // Overcurrent shut forces all gates off next cycle
    chk_oc_off: assert property (@(posedge core_clk) disable iff (!resetn)
        oc_fault |=> (gates == '0))
        else $error("Gates on during overcurrent shutdown");

    // Trip in sense state starts off time
    sequence seq_trip;
        chop == dhbdc_pkg::DHBDC_CH_SENSE && driving && sense_trip && !force_off && !oc_fault;
    endsequence
    chk_trip_off: assert property (@(posedge core_clk) disable iff (!resetn)
        seq_trip |=> chop_off [*8])
        else $error("Off time not held after trip");

    // Blank ignores comparator
    chk_blank_ign: assert property (@(posedge core_clk) disable iff (!resetn)
        (chop == dhbdc_pkg::DHBDC_CH_BLANK && chop_cnt != '0) |=> !chop_off)
        else $error("Trip acted on during blanking");

    // Off time ends on count
    chk_off_end: assert property (@(posedge core_clk) disable iff (!resetn)
        (chop_off && chop_cnt == '0 && !force_off) |=> !chop_off)
        else $error("Off time did not end");
endmodule
`default_nettype wire

// ===== design/dhbdc_top.sv
// Dual H-bridge drive control top: sync, sleep, protection, two bridges
//
// Behaviour
// - Inputs 00 coast Z, 01 reverse, 10 forward, 11 brake low.
// - Fast decay turns every FET of the bridge off.
// - Slow decay: high sides off, both low sides on.
// - Chopping stays active under external PWM; grounded sense defeats it.
// - Constant 20 us off time; drive withheld after threshold reached.
// - Sense comparator ignored for 3.75 us after bridge turn-on.
// - Comparator output at 200 mV reference is the trip event.
// - On trip, slow decay for 20 us, then high sides re-enabled.
// - Sleep low disables bridges and holds logic in reset.
// - Bridge inputs ignored during sleep.
// - Persistent FET limit past deglitch disables bridge, fault low.
// - After retry period bridge re-enabled, fault released; repeats if present.
// - Overcurrent shuts only the bridge where it was detected.
// - Overcurrent detected per FET, independent of chopping sense path.
// - Overtemperature disables FETs, fault low; resume on cooling, then release. Here fault releases first, FETs after the dead time.
// - Undervoltage disables and resets logic, no fault; resumes above 2.7 V.
// - Internal dead time between FET switching prevents cross-conduction.
`include "dhbdc_params.svh"
`default_nettype none
module dhbdc_top (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic resetn,
    // Bridge control pins
    input  wire logic bridge_a_ctl_one,
    input  wire logic bridge_a_ctl_two,
    input  wire logic bridge_b_ctl_one,
    input  wire logic bridge_b_ctl_two,
    input  wire logic sleep_input_n,
    // Analog comparator flags
    input  wire logic sense_trip_a,
    input  wire logic sense_trip_b,
    input  wire logic fet_limit_a,
    input  wire logic fet_limit_b,
    input  wire logic over_temp,
    input  wire logic supply_low,
    // Gate enables per half bridge
    output logic      bridge_a_drive_one_hs,
    output logic      bridge_a_drive_one_ls,
    output logic      bridge_a_drive_two_hs,
    output logic      bridge_a_drive_two_ls,
    output logic      bridge_b_drive_one_hs,
    output logic      bridge_b_drive_one_ls,
    output logic      bridge_b_drive_two_hs,
    output logic      bridge_b_drive_two_ls,
    // Open-drain fault pin, enable low while pulling low
    output logic      fault_output_n_out,
    output logic      fault_output_n_oe_n
);
    logic [10:0] raw, syn;
    logic        ctl_a1, ctl_a2, ctl_b1, ctl_b2, awake, trip_a, trip_b;
    logic        lim_a, lim_b, hot, low_supply;
    logic        force_off, oc_a, oc_b, fault, next_fault;
    logic        chop_a, chop_b;

    // All pins come from outside the clock domain
    assign raw = {bridge_a_ctl_one, bridge_a_ctl_two, bridge_b_ctl_one, bridge_b_ctl_two,
                  sleep_input_n, sense_trip_a, sense_trip_b, fet_limit_a, fet_limit_b,
                  over_temp, supply_low};

    dhbdc_sync #(.WIDTH(11)) u_sync (
        .core_clk (core_clk),
        .resetn   (resetn),
        .pin_in   (raw),
        .sync_out (syn)
    );

    assign {ctl_a1, ctl_a2, ctl_b1, ctl_b2, awake, trip_a, trip_b,
            lim_a, lim_b, hot, low_supply} = syn;

    // Sleep and undervoltage hold both bridges in reset-off
    // Overtemperature disables FETs while timers stay idle
    assign force_off = !awake || low_supply || hot;

    // Inputs masked while asleep
    dhbdc_bridge u_bridge_a (
        .core_clk   (core_clk),
        .resetn     (resetn),
        .ctl_one    (ctl_a1 & awake),
        .ctl_two    (ctl_a2 & awake),
        .sense_trip (trip_a),
        .fet_limit  (lim_a),
        .force_off  (force_off),
        .hs_one     (bridge_a_drive_one_hs),
        .ls_one     (bridge_a_drive_one_ls),
        .hs_two     (bridge_a_drive_two_hs),
        .ls_two     (bridge_a_drive_two_ls),
        .oc_fault   (oc_a),
        .chop_off   (chop_a)
    ); // Own timers and fault state per bridge

    dhbdc_bridge u_bridge_b (
        .core_clk   (core_clk),
        .resetn     (resetn),
        .ctl_one    (ctl_b1 & awake),
        .ctl_two    (ctl_b2 & awake),
        .sense_trip (trip_b),
        .fet_limit  (lim_b),
        .force_off  (force_off),
        .hs_one     (bridge_b_drive_one_hs),
        .ls_one     (bridge_b_drive_one_ls),
        .hs_two     (bridge_b_drive_two_hs),
        .ls_two     (bridge_b_drive_two_ls),
        .oc_fault   (oc_b),
        .chop_off   (chop_b)
    );

    // Fault report: overcurrent or overtemperature, never undervoltage or sleep
    always_comb begin
        next_fault = 1'b0;
        if (awake && !low_supply) begin
            next_fault = oc_a || oc_b || hot;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            fault <= 1'b0;
        end else begin
            fault <= next_fault;
        end
    end

    // Output held low, enable asserted (low) only while reporting
    assign fault_output_n_out  = 1'b0;
    assign fault_output_n_oe_n = !fault;

    // Sleep forces the half-one gates of both bridges off within two cycles
    chk_sleep_off: assert property (@(posedge core_clk) disable iff (!resetn)
        (!awake) |-> ##2 !(bridge_a_drive_one_hs || bridge_a_drive_one_ls ||
                          bridge_b_drive_one_hs || bridge_b_drive_one_ls))
        else $error("Gates on while asleep");

    // Undervoltage never reports a fault
    chk_uv_nofault: assert property (@(posedge core_clk) disable iff (!resetn)
        low_supply |=> fault_output_n_oe_n)
        else $error("Fault pulled during undervoltage");

    // Overtemperature reports a fault next cycle
    chk_hot_fault: assert property (@(posedge core_clk) disable iff (!resetn)
        (hot && awake && !low_supply) |=> !fault_output_n_oe_n)
        else $error("No fault on overtemperature");

    // Bridge B shutdown leaves A's fault state alone
    chk_oc_indep: assert property (@(posedge core_clk) disable iff (!resetn)
        ($rose(oc_b) && !lim_a && !oc_a) |=> !oc_a)
        else $error("Overcurrent crossed bridges");

    // Fault follows overcurrent state
    chk_oc_fault: assert property (@(posedge core_clk) disable iff (!resetn)
        (oc_a && awake && !low_supply) |=> fault)
        else $error("No fault on overcurrent");
endmodule
`default_nettype wire

// ===== testbench/dhbdc_ctl_model.sv
// Controller model driving the bridge and sleep pins
`default_nettype none
module dhbdc_ctl_model (
    // Clock
    input  wire logic       core_clk,
    // Requested levels and PWM set-up
    input  wire logic [1:0] lvl_a,
    input  wire logic [1:0] lvl_b,
    input  wire logic       pwm_on,
    input  wire logic       pwm_slow,
    input  wire logic       sleep_req,
    // Pins towards the driver
    output logic            a_one,
    output logic            a_two,
    output logic            b_one,
    output logic            b_two,
    output logic            sleep_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int   cnt = 0;
    logic ph  = 1'b0;
    // Half period of 100 cycles, long enough to outlast the dead time
    // Non-blocking so a bench sampling on the same edge sees a settled level
    always @(negedge core_clk) begin
        cnt <= (cnt == 99) ? 0 : cnt + 1;
        if (cnt == 99) ph <= ~ph;
    end
    // Fast decay PWMs input one, two low; slow decay holds one high
    assign a_one = pwm_on ? (pwm_slow ? 1'b1 : ph) : lvl_a[1];
    assign a_two = pwm_on ? (pwm_slow ? ph : 1'b0) : lvl_a[0];
    assign {b_one, b_two} = lvl_b;
    assign sleep_n = ~sleep_req;
endmodule
`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench for the dual bridge drive control
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic            core_clk  = 1'b0;
    logic            resetn    = 1'b0;
    logic [1:0]      lvl_a     = 2'h0;
    logic [1:0]      lvl_b     = 2'h0;
    logic            pwm_on    = 1'b0;
    logic            pwm_slow  = 1'b0;
    logic            sleep_req = 1'b0;
    logic            trip_a    = 1'b0;
    logic            trip_b    = 1'b0;
    logic            lim_a     = 1'b0;
    logic            lim_b     = 1'b0;
    logic            hot       = 1'b0;
    logic            low_v     = 1'b0;
    wire logic       a_one, a_two, b_one, b_two, sleep_n, f_out, f_oe_n;
    wire logic [3:0] ga, gb;
    int              err_count    = 0;
    int              total_checks = 0;

    // Controller on the far side of the pins
    dhbdc_ctl_model u_ctl (.core_clk(core_clk), .lvl_a(lvl_a), .lvl_b(lvl_b),
        .pwm_on(pwm_on), .pwm_slow(pwm_slow), .sleep_req(sleep_req), .a_one(a_one),
        .a_two(a_two), .b_one(b_one), .b_two(b_two), .sleep_n(sleep_n));

    // Gate groups read as {one_hs, one_ls, two_hs, two_ls}
    dhbdc_top u_dut (.core_clk(core_clk), .resetn(resetn),
        .bridge_a_ctl_one(a_one), .bridge_a_ctl_two(a_two),
        .bridge_b_ctl_one(b_one), .bridge_b_ctl_two(b_two), .sleep_input_n(sleep_n),
        .sense_trip_a(trip_a), .sense_trip_b(trip_b), .fet_limit_a(lim_a),
        .fet_limit_b(lim_b), .over_temp(hot), .supply_low(low_v),
        .bridge_a_drive_one_hs(ga[3]), .bridge_a_drive_one_ls(ga[2]),
        .bridge_a_drive_two_hs(ga[1]), .bridge_a_drive_two_ls(ga[0]),
        .bridge_b_drive_one_hs(gb[3]), .bridge_b_drive_one_ls(gb[2]),
        .bridge_b_drive_two_hs(gb[1]), .bridge_b_drive_two_ls(gb[0]),
        .fault_output_n_out(f_out), .fault_output_n_oe_n(f_oe_n));

    // Reference decode of an input pair
    function automatic logic [3:0] model(input int code);
        case (code)
            1: return 4'h6;
            2: return 4'h9;
            3: return 4'h5;
            default: return 4'h0;
        endcase
    endfunction

    task automatic check(input logic [3:0] seen, input logic [3:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // Bounded wait: sel 0 fault enable, 1 input two, 2 input one
    task automatic wait_lvl(input int sel, input logic v, input int lim);
        logic s;
        for (int i = 0; i < lim; i++) begin
            @(negedge core_clk);
            s = (sel == 0) ? f_oe_n : (sel == 1) ? a_two : a_one;
            if (s === v) return;
        end
        err_count++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        complete_run;
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    // Hang guard, well past the 140000-cycle retry
    initial begin
        #2500000;
        err_count++;
        $display("CHECK FAILED at %0t: run timed out", $time);
        complete_run;
    end

    // No half may ever have both FETs on
    always @(negedge core_clk) begin
        if (resetn) begin
            check({ga[3] & ga[2], ga[1] & ga[0], gb[3] & gb[2], gb[1] & gb[0]}, 4'h0,
                  "shoot-through");
        end
    end

    initial begin
        int q[$];
        int c;
        void'($urandom(2351));
        cyc(5);
        check(ga | gb, 4'h0, "gates in reset");
        check({f_out, 2'h0, f_oe_n}, 4'h1, "fault pin in reset");
        cyc(7);
        resetn = 1'b1;
        // Random codes, then every code on both bridges
        for (int i = 0; i < 8; i++) q.push_back($urandom % 16);
        for (int i = 0; i < 4; i++) q.push_back(i * 5);
        while (q.size() > 0) begin
            c = q.pop_front();
            lvl_a = c[3:2];
            lvl_b = c[1:0];
            cyc(60);
            check(ga, model(c / 4), "decode a");
            check(gb, model(c % 4), "decode b");
        end
        // Forward straight to reverse must pass through all off
        lvl_a = 2'h2;
        cyc(60);
        lvl_a = 2'h1;
        cyc(20);
        check(ga, 4'h0, "dead time");
        cyc(40);
        check(ga, 4'h6, "reverse");
        $display("test decode done");
        // Trip held from turn-on: blanked first, then slow decay
        lvl_a = 2'h0;
        cyc(60);
        trip_a = 1'b1;
        lvl_a = 2'h2;
        cyc(200);
        check(ga, 4'h9, "blanking");
        cyc(250);
        check(ga, 4'h5, "chop decay");
        check(gb, 4'h5, "b steady");
        trip_a = 1'b0;
        cyc(1900);
        check(ga, 4'h5, "off time");
        cyc(250);
        check(ga, 4'h9, "rearmed");
        $display("test chopper done");
        // External PWM, fast then slow decay
        for (int m = 0; m < 2; m++) begin
            pwm_slow = m[0];
            pwm_on = 1'b1;
            wait_lvl(2 - m, 1'b0, 300);
            wait_lvl(2 - m, 1'b1, 300);
            cyc(90);
            check(ga, m ? 4'h5 : 4'h9, "pwm high");
            cyc(100);
            check(ga, m ? 4'h9 : 4'h0, "pwm low");
        end
        pwm_on = 1'b0;
        $display("test pwm done");
        // Limit on bridge b only, short then long
        lvl_a = 2'h1;
        lvl_b = 2'h2;
        cyc(60);
        lim_b = 1'b1;
        cyc(200);
        lim_b = 1'b0;
        cyc(5);
        check({gb[3:1], f_oe_n}, 4'h9, "deglitch");
        lim_b = 1'b1;
        wait_lvl(0, 1'b0, 300);
        check(gb, 4'h0, "oc off");
        check(ga, 4'h6, "other bridge");
        lim_b = 1'b0;
        // Limit on bridge a while b is still shut, each on its own retry timer
        lim_a = 1'b1;
        cyc(240);
        check(ga, 4'h0, "oc a off");
        check({3'h0, f_oe_n}, 4'h0, "oc a fault");
        lim_a = 1'b0;
        cyc(139000);
        check({3'h0, f_oe_n}, 4'h0, "retry hold");
        wait_lvl(0, 1'b1, 2000);
        cyc(60);
        check(gb, 4'h9, "retried");
        check(ga, 4'h6, "a retried");
        $display("test overcurrent done");
        // Overtemperature, then undervoltage masking it
        hot = 1'b1;
        cyc(10);
        check({ga | gb}, 4'h0, "hot off");
        check({3'h0, f_oe_n}, 4'h0, "hot fault");
        hot = 1'b0;
        cyc(60);
        check({gb[3:1], f_oe_n}, 4'h9, "hot resume");
        low_v = 1'b1;
        hot = 1'b1;
        cyc(10);
        check(ga | gb, 4'h0, "uv off");
        check({3'h0, f_oe_n}, 4'h1, "uv no fault");
        low_v = 1'b0;
        hot = 1'b0;
        cyc(60);
        check(ga, 4'h6, "uv resume");
        $display("test protection done");
        // Sleep, input change while asleep, wake
        sleep_req = 1'b1;
        cyc(10); // entry allowance
        check(ga | gb, 4'h0, "asleep");
        lvl_a = 2'h3;
        cyc(60);
        check(ga, 4'h0, "ignored");
        sleep_req = 1'b0;
        cyc(60); // wake allowance
        check(ga, 4'h5, "woken");
        $display("test sleep done");
        complete_run;
    end
endmodule
`default_nettype wire
